// [verilog/period_timer_pkg.sv]
// Package for the period timer: register indices, field layout, reset
// values, the state record and the time-base carrier.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
`default_nettype none

package period_timer_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAGS   = 8'h0C;
  localparam logic [7:0] IDX_COUNT   = 8'h11;
  localparam logic [7:0] IDX_CONTROL = 8'h12;
  localparam logic [7:0] IDX_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_LIMIT   = 8'h92;

  // Field positions
  localparam int          MATCH_BIT   = 1;
  localparam int          RUN_BIT     = 2;
  localparam int          PRE_LO      = 0;
  localparam int          POST_LO     = 3;

  // Reset values
  localparam logic [7:0] COUNT_RST   = 8'h00;
  localparam logic [7:0] LIMIT_RST   = 8'hFF;
  localparam logic [6:0] CONTROL_RST = 7'h00;

  // Instruction clock is the bus clock divided by four
  localparam logic [1:0] INST_LAST   = 2'h3;

  // Prescaler terminal counts for divide by 1, 4 and 16
  localparam logic [3:0] PRE_LAST_1  = 4'h0;
  localparam logic [3:0] PRE_LAST_4  = 4'h3;
  localparam logic [3:0] PRE_LAST_16 = 4'hF;

  typedef struct packed {
    logic [7:0] count;
    logic       match;
  } time_base_t;

  typedef struct packed {
    logic [7:0] count_q;
    logic [7:0] limit_q;
    logic [6:0] control_q;
    logic [3:0] pre_q;
    logic [3:0] post_q;
    logic [1:0] inst_q;
    logic       flag_q;
    logic       enable_q;
    logic       match_q;
    logic       wr_q;
    logic [7:0] idx_q;
    logic [7:0] rdata_q;
  } state_t;

endpackage

`default_nettype wire

// [verilog/period_timer.sv]
// Period timer with prescaler and postscaler behind an AHB-Lite slave.
// Assumes hclk is the oscillator clock, one bus master, word transfers.
`default_nettype none

module period_timer (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output      logic                          hreadyout,
  output      logic [31:0]                   hrdata,
  output      logic                          hresp,
  output      logic                          irq,
  output      logic                          ssp_match,
  output      period_timer_pkg::time_base_t  time_base
);

  period_timer_pkg::state_t s_q;
  period_timer_pkg::state_t s_d;

  logic       addr_ok;
  logic       take;
  logic       wr_count;
  logic       wr_control;
  logic       wr_limit;
  logic       wr_flags;
  logic       wr_enables;
  logic       run;
  logic       inst_en;
  logic       tick;
  logic       at_limit;
  logic       post_hit;
  logic       match_now;
  logic       flag_set;
  logic [7:0] wbyte;

  // Terminal count of the prescaler for a given select code
  function automatic logic [3:0] pre_last(input logic [1:0] sel);
    logic [3:0] r;
    r = period_timer_pkg::PRE_LAST_16;
    case (sel)
      2'h0:    r = period_timer_pkg::PRE_LAST_1;
      2'h1:    r = period_timer_pkg::PRE_LAST_4;
      default: r = period_timer_pkg::PRE_LAST_16;
    endcase
    return r;
  endfunction

  // Read value of a register; unmapped indices read zero
  function automatic logic [7:0] read_reg(
    input logic [7:0]               idx,
    input period_timer_pkg::state_t st
  );
    logic [7:0] r;
    r = 8'h00;
    case (idx)
      period_timer_pkg::IDX_FLAGS:
        r[period_timer_pkg::MATCH_BIT] = st.flag_q;
      period_timer_pkg::IDX_ENABLES:
        r[period_timer_pkg::MATCH_BIT] = st.enable_q;
      period_timer_pkg::IDX_COUNT:   r = st.count_q;
      period_timer_pkg::IDX_CONTROL: r = {1'b0, st.control_q};
      period_timer_pkg::IDX_LIMIT:   r = st.limit_q;
      default:                       r = 8'h00;
    endcase
    return r;
  endfunction

  // Address phase decode: index sits in haddr[9:2], upper bits must be 0
  assign addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  assign take    = hsel && htrans[1] && hready;

  // Data phase writes use the low byte lane only
  assign wbyte      = hwdata[7:0];
  assign wr_count   = s_q.wr_q && (s_q.idx_q == period_timer_pkg::IDX_COUNT);
  assign wr_control = s_q.wr_q &&
                      (s_q.idx_q == period_timer_pkg::IDX_CONTROL);
  assign wr_limit   = s_q.wr_q && (s_q.idx_q == period_timer_pkg::IDX_LIMIT);
  assign wr_flags   = s_q.wr_q && (s_q.idx_q == period_timer_pkg::IDX_FLAGS);
  assign wr_enables = s_q.wr_q &&
                      (s_q.idx_q == period_timer_pkg::IDX_ENABLES);

  assign run      = s_q.control_q[period_timer_pkg::RUN_BIT];
  assign inst_en  = (s_q.inst_q == period_timer_pkg::INST_LAST);
  assign tick     = inst_en && run &&
                    (s_q.pre_q ==
                     pre_last(s_q.control_q[period_timer_pkg::PRE_LO +: 2]));
  assign at_limit = (s_q.count_q == s_q.limit_q);
  assign post_hit = (s_q.post_q ==
                     s_q.control_q[period_timer_pkg::POST_LO +: 4]);
  // A counter or control write in the same cycle takes precedence
  assign match_now = tick && at_limit && !wr_count && !wr_control;
  assign flag_set  = match_now && post_hit;

  always_comb begin
    s_d          = s_q;
    s_d.match_q  = 1'b0;

    // Instruction clock phase runs free so the rate never drifts
    s_d.inst_q = s_q.inst_q + 2'h1;

    // Prescaler and counter only move while running
    if (inst_en && run) begin
      if (tick) begin
        s_d.pre_q = 4'h0;
      end else begin
        s_d.pre_q = s_q.pre_q + 4'h1;
      end
    end

    if (tick) begin
      if (at_limit) begin
        s_d.count_q = 8'h00;
      end else begin
        s_d.count_q = s_q.count_q + 8'h01;
      end
    end

    if (match_now) begin
      s_d.match_q = 1'b1;
      if (post_hit) begin
        s_d.post_q = 4'h0;
      end else begin
        s_d.post_q = s_q.post_q + 4'h1;
      end
    end

    // Register writes override the counting above
    if (wr_count) begin
      s_d.count_q = wbyte;
      s_d.pre_q   = 4'h0;
      s_d.post_q  = 4'h0;
    end
    if (wr_control) begin
      s_d.control_q = wbyte[6:0];
      s_d.count_q   = s_q.count_q;
      s_d.pre_q     = 4'h0;
      s_d.post_q    = 4'h0;
    end
    if (wr_limit) begin
      s_d.limit_q = wbyte;
    end
    if (wr_enables) begin
      s_d.enable_q = wbyte[period_timer_pkg::MATCH_BIT];
    end

    // Set beats a write-one clear arriving in the same cycle
    s_d.flag_q = flag_set ||
                 (s_q.flag_q &&
                  !(wr_flags && wbyte[period_timer_pkg::MATCH_BIT]));

    // Address phase capture; read data is taken from the next state so
    // a read right behind a write sees the written value
    s_d.wr_q = take && hwrite && addr_ok;
    s_d.idx_q = haddr[9:2];
    if (take && !hwrite) begin
      s_d.rdata_q = addr_ok ? read_reg(haddr[9:2], s_d) : 8'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q           <= '0;
      s_q.count_q   <= period_timer_pkg::COUNT_RST;
      s_q.limit_q   <= period_timer_pkg::LIMIT_RST;
      s_q.control_q <= period_timer_pkg::CONTROL_RST;
      s_q.pre_q     <= 4'h0;
      s_q.post_q    <= 4'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // Zero wait state slave; every response is OKAY
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign hrdata          = {24'h000000, s_q.rdata_q};
  assign irq             = s_q.flag_q && s_q.enable_q;
  assign ssp_match       = s_q.match_q;
  assign time_base       = '{count: s_q.count_q, match: s_q.match_q};

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  wrap_to_zero_a: assert property (
    match_now |=> (s_q.count_q == 8'h00) && ssp_match
  ) else $error("counter did not wrap to zero at limit");

  count_step_a: assert property (
    tick && !at_limit && !wr_count && !wr_control
      |=> s_q.count_q == $past(s_q.count_q) + 8'h01
  ) else $error("counter did not step on prescaler pulse");

  stopped_hold_a: assert property (
    !run && !s_q.wr_q |=> $stable(s_q.count_q) && $stable(s_q.pre_q)
                           && $stable(s_q.post_q)
  ) else $error("stopped timer changed state");

  control_keeps_count_a: assert property (
    wr_control |=> s_q.count_q == $past(s_q.count_q)
  ) else $error("control write disturbed the counter");

  scalers_cleared_a: assert property (
    wr_count || wr_control |=> s_q.pre_q == 4'h0 && s_q.post_q == 4'h0
  ) else $error("scalers not cleared by write");

  tick_spacing_a: assert property (
    tick |=> !tick [*3]
  ) else $error("prescaler pulse faster than instruction clock");

  post_advance_a: assert property (
    match_now && !post_hit |=> s_q.post_q == $past(s_q.post_q) + 4'h1
                               && !$rose(s_q.flag_q)
  ) else $error("postscaler did not advance on match");

  flag_latch_a: assert property (
    flag_set |=> s_q.flag_q && irq == s_q.enable_q
  ) else $error("postscaled match did not set flag");

  bit7_reads_zero_a: assert property (
    take && !hwrite && haddr[9:2] == period_timer_pkg::IDX_CONTROL
      |=> hrdata[7] == 1'b0
  ) else $error("control bit 7 read as one");

  limit_write_a: assert property (
    wr_limit |=> s_q.limit_q == $past(hwdata[7:0])
  ) else $error("period limit write lost");

  // Register access; a read returns the next state seen at the address
  // edge, so it matches the registered state one cycle later
  count_write_a: assert property (
    wr_count |=> s_q.count_q == $past(hwdata[7:0])
  ) else $error("counter write lost");

  count_read_a: assert property (
    take && !hwrite && addr_ok && haddr[9:2] == period_timer_pkg::IDX_COUNT
      |=> hrdata[7:0] == s_q.count_q
  ) else $error("counter read wrong");

  limit_hold_a: assert property (
    !wr_limit |=> $stable(s_q.limit_q)
  ) else $error("period limit changed without a write");

  limit_read_a: assert property (
    take && !hwrite && addr_ok && haddr[9:2] == period_timer_pkg::IDX_LIMIT
      |=> hrdata[7:0] == s_q.limit_q
  ) else $error("period limit read wrong");

  control_write_a: assert property (
    wr_control |=> s_q.control_q == $past(hwdata[6:0])
  ) else $error("control write lost");

  control_hold_a: assert property (
    !wr_control |=> $stable(s_q.control_q)
  ) else $error("control changed without a write");

  control_read_a: assert property (
    take && !hwrite && addr_ok && haddr[9:2] == period_timer_pkg::IDX_CONTROL
      |=> hrdata[7:0] == {1'b0, s_q.control_q}
  ) else $error("control read wrong");

  enable_write_a: assert property (
    wr_enables
      |=> s_q.enable_q == $past(hwdata[period_timer_pkg::MATCH_BIT])
  ) else $error("interrupt enable write lost");

  enable_hold_a: assert property (
    !wr_enables |=> $stable(s_q.enable_q)
  ) else $error("interrupt enable changed without a write");

  enables_read_a: assert property (
    take && !hwrite && addr_ok && haddr[9:2] == period_timer_pkg::IDX_ENABLES
      |=> hrdata[period_timer_pkg::MATCH_BIT] == s_q.enable_q
          && hrdata[31:8] == 24'h000000
  ) else $error("interrupt enable read wrong");

  unmapped_read_a: assert property (
    take && !hwrite && !addr_ok |=> hrdata == 32'h00000000
  ) else $error("unmapped read not zero");

  // Scalers and counter
  pre_range_a: assert property (
    s_q.pre_q <= pre_last(s_q.control_q[period_timer_pkg::PRE_LO +: 2])
  ) else $error("prescaler passed its terminal count");

  pre_clear_a: assert property (
    tick |=> s_q.pre_q == 4'h0
  ) else $error("prescaler not restarted after its pulse");

  pre_step_a: assert property (
    run && inst_en && !tick && !s_q.wr_q
      |=> s_q.pre_q == $past(s_q.pre_q) + 4'h1
  ) else $error("running prescaler did not advance");

  stop_quiet_a: assert property (
    !run |=> !ssp_match
  ) else $error("stopped timer produced a match");

  wrap_only_a: assert property (
    tick && !at_limit |=> !ssp_match
  ) else $error("match pulse below the period limit");

  count_hold_a: assert property (
    !tick && !s_q.wr_q |=> $stable(s_q.count_q)
  ) else $error("counter moved without a prescaler pulse");

  post_hold_a: assert property (
    !match_now && !s_q.wr_q |=> $stable(s_q.post_q)
  ) else $error("postscaler moved without a match");

  post_range_a: assert property (
    s_q.post_q <= s_q.control_q[period_timer_pkg::POST_LO +: 4]
  ) else $error("postscaler passed its selected ratio");

  post_wrap_a: assert property (
    flag_set |=> s_q.post_q == 4'h0
  ) else $error("postscaler not restarted after flag set");

  write_drops_match_a: assert property (
    wr_count || wr_control |=> !ssp_match
  ) else $error("match pulse despite counter or control write");

  // Interrupt flag
  flag_quiet_a: assert property (
    !flag_set && !s_q.flag_q |=> !s_q.flag_q
  ) else $error("flag set without a postscaled match");

  flag_sticky_a: assert property (
    s_q.flag_q && !wr_flags |=> s_q.flag_q
  ) else $error("flag dropped without a clear");

  flag_clear_a: assert property (
    wr_flags && wbyte[period_timer_pkg::MATCH_BIT] && !flag_set
      |=> !s_q.flag_q
  ) else $error("write of one did not clear the flag");

  flag_read_a: assert property (
    take && !hwrite && addr_ok && haddr[9:2] == period_timer_pkg::IDX_FLAGS
      |=> hrdata[period_timer_pkg::MATCH_BIT] == s_q.flag_q
          && hrdata[31:8] == 24'h000000
  ) else $error("flag read wrong");

  match_with_flag_a: assert property (
    flag_set |=> ssp_match
  ) else $error("flag set without a match pulse");

  // Outputs to the serial port and the PWM block
  match_pulse_a: assert property (
    ssp_match |=> !ssp_match
  ) else $error("match pulse longer than one cycle");

  base_zero_a: assert property (
    time_base.match |-> time_base.count == 8'h00
  ) else $error("time base match with nonzero count");

endmodule // period_timer

`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the period timer: registers, scalers, interrupt.
// Assumes the design package and module of verilog/ are compiled first.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                         hclk;
  logic                         hresetn;
  logic                         hsel;
  logic [31:0]                  haddr;
  logic [1:0]                   htrans;
  logic                         hwrite;
  logic [2:0]                   hsize;
  logic [31:0]                  hwdata;
  logic                         hreadyout;
  logic [31:0]                  hrdata;
  logic                         hresp;
  logic                         irq;
  logic                         ssp_match;
  period_timer_pkg::time_base_t time_base;
  logic [31:0]                  rd;
  int                           n_fail;
  int                           n_checks;

  period_timer i_period_timer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .irq(irq), .ssp_match(ssp_match), .time_base(time_base)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("Counts: %0d checks, %0d mismatches", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    n_fail++;
    $display("MISMATCH at %0t: timeout in %s", $time, what);
    results();
  endtask

  task automatic wait_ready();
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && i < 50) begin
      @(posedge hclk);
      i++;
    end
    if (i >= 50) begin
      hang("bus");
    end
  endtask

  // Read data is taken at the edge ending the data phase
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h000000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    wait_ready();
    rd = hrdata;
    check(32'(hresp), 32'h00000000);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask

  task automatic count_pulses(output int n);
    int i;
    n = 0;
    i = 0;
    while (irq !== 1'b1 && i < 1000) begin
      @(negedge hclk);
      if (ssp_match === 1'b1) begin
        n++;
        check(32'(time_base.count), 32'h00000000);
        check(32'(time_base.match), 32'h00000001);
      end
      i++;
    end
    if (i >= 1000) begin
      hang("irq");
    end
  endtask

  task automatic t_reset();
    rdchk(period_timer_pkg::IDX_COUNT, 32'h00000000);
    rdchk(period_timer_pkg::IDX_LIMIT, 32'h000000FF);
    rdchk(period_timer_pkg::IDX_CONTROL, 32'h00000000);
    rdchk(period_timer_pkg::IDX_FLAGS, 32'h00000000);
    rdchk(period_timer_pkg::IDX_ENABLES, 32'h00000000);
    $display("test reset done");
  endtask

  task automatic t_regs();
    wr(period_timer_pkg::IDX_COUNT, 8'h5A);
    rdchk(period_timer_pkg::IDX_COUNT, 32'h0000005A);
    wr(period_timer_pkg::IDX_LIMIT, 8'h3C);
    rdchk(period_timer_pkg::IDX_LIMIT, 32'h0000003C);
    wr(period_timer_pkg::IDX_CONTROL, 8'hFB);
    rdchk(period_timer_pkg::IDX_CONTROL, 32'h0000007B);
    rdchk(period_timer_pkg::IDX_COUNT, 32'h0000005A);
    wr(8'h13, 8'h55);
    rdchk(8'h13, 32'h00000000);
    $display("test registers done");
  endtask

  // Cycles until the counter next changes; a stuck counter ends the run
  task automatic step_gap(output int n);
    logic [7:0] c;
    c = time_base.count;
    n = 0;
    while (time_base.count === c && n < 200) begin
      @(negedge hclk);
      n++;
    end
    if (n >= 200) begin
      hang("count");
    end
  endtask

  task automatic t_pre();
    int   div[4] = '{4, 16, 64, 64};
    int   n;
    logic [7:0] c;
    wr(period_timer_pkg::IDX_LIMIT, 8'hFF);
    for (int p = 0; p < 4; p++) begin
      wr(period_timer_pkg::IDX_CONTROL, 8'h04 | 8'(p));
      @(negedge hclk);
      step_gap(n);
      c = time_base.count;
      step_gap(n);
      check(32'(n), 32'(div[p]));
      check(32'(time_base.count), 32'(c + 8'h01));
    end
    $display("test prescale done");
  endtask

  // Stopping first keeps a stray match from landing after the flag clear
  task automatic t_post(input logic [3:0] k);
    int n;
    wr(period_timer_pkg::IDX_CONTROL, 8'h00);
    wr(period_timer_pkg::IDX_FLAGS, 8'h02);
    wr(period_timer_pkg::IDX_LIMIT, 8'h02);
    wr(period_timer_pkg::IDX_ENABLES, 8'h02);
    wr(period_timer_pkg::IDX_COUNT, 8'h00);
    wr(period_timer_pkg::IDX_CONTROL, {1'b0, k, 3'b100});
    count_pulses(n);
    check(32'(n), 32'(k) + 32'h1);
    rdchk(period_timer_pkg::IDX_FLAGS, 32'h00000002);
    $display("test postscale %0d done", k);
  endtask

  task automatic t_irq();
    wr(period_timer_pkg::IDX_CONTROL, 8'h00);
    wr(period_timer_pkg::IDX_ENABLES, 8'h00);
    @(negedge hclk);
    check(32'(irq), 32'h00000000);
    wr(period_timer_pkg::IDX_ENABLES, 8'h02);
    @(negedge hclk);
    check(32'(irq), 32'h00000001);
    wr(period_timer_pkg::IDX_FLAGS, 8'h02);
    @(negedge hclk);
    check(32'(irq), 32'h00000000);
    rdchk(period_timer_pkg::IDX_FLAGS, 32'h00000000);
    $display("test interrupt done");
  endtask

  task automatic t_count_clear();
    int n;
    wr(period_timer_pkg::IDX_CONTROL, 8'h00);
    wr(period_timer_pkg::IDX_FLAGS, 8'h02);
    wr(period_timer_pkg::IDX_LIMIT, 8'h00);
    wr(period_timer_pkg::IDX_COUNT, 8'h00);
    wr(period_timer_pkg::IDX_CONTROL, 8'h0E);
    n = 0;
    while (ssp_match !== 1'b1 && n < 200) begin
      @(negedge hclk);
      n++;
    end
    if (n >= 200) begin
      hang("match");
    end
    check(32'(irq), 32'h00000000);
    wr(period_timer_pkg::IDX_COUNT, 8'h00);
    count_pulses(n);
    check(32'(n), 32'h00000002);
    $display("test count write clear done");
  endtask

  task automatic t_stop();
    wr(period_timer_pkg::IDX_LIMIT, 8'hFF);
    wr(period_timer_pkg::IDX_CONTROL, 8'h06);
    repeat (200) @(negedge hclk);
    wr(period_timer_pkg::IDX_CONTROL, 8'h02);
    bus(1'b0, period_timer_pkg::IDX_COUNT, 8'h00);
    repeat (300) @(negedge hclk);
    rdchk(period_timer_pkg::IDX_COUNT, rd);
    $display("test stop done");
  endtask

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  initial begin
    hresetn  = 1'b0;
    hsel     = 1'b0;
    haddr    = 32'h00000000;
    htrans   = 2'h0;
    hwrite   = 1'b0;
    hsize    = 3'h2;
    hwdata   = 32'h00000000;
    rd       = 32'h00000000;
    n_fail   = 0;
    n_checks = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_regs();
    t_pre();
    t_post(4'h0);
    t_irq();
    t_post(4'h1);
    t_post(4'hF);
    t_count_clear();
    t_stop();
    results();
  end
endmodule // tb_top

`default_nettype wire
